// file: hw/tbl_ind_core.sv
// Table-indirect instruction and bank-select execution block with APB registers
//
// Operation
// - Bank select takes two machine cycles; loads register bank 0-3 or memory bank 0,1,15.
// - Branch entry loads PC from second byte plus 4/5/6 low first-byte bits; 3 cycles.
// - Legacy call pushes PC in three nibbles plus flags nibble; pointer drops by 4.
// - Extended call takes 4 cycles, writes five-nibble frame; pointer drops by 6.
// - Other entries execute the stored two-byte instruction in 3 cycles; its own skip.
// - Stack mode selects four-nibble or five-nibble call frame.
// - Instruction is one byte; entry contents are interpreted at execution.
`timescale 1ns/10ps
module tbl_ind_core
    import tbl_ind_pkg::*;
#(
    parameter int MC_CLKS = MC_DIV
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Program memory holding the table
    output mem_t             mem,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    // Stack write port
    output stk_t             stk,
    // Referenced instruction hand-off
    output logic             exec_go,
    output logic [15:0]      exec_ins,
    // Status
    output logic             busy,
    output logic             io_ok
);
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH_LO, ST_FETCH_HI, ST_PUSH, ST_WAIT} state_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] hi_mask(input logic [1:0] pcw);
        case (pcw)
            2'd0:    hi_mask = 6'h0F;
            2'd1:    hi_mask = 6'h1F;
            default: hi_mask = 6'h3F;
        endcase
    endfunction

    // Offset below SP and nibble for push step idx
    function automatic logic [11:0] frame_nib(input logic ext, input logic [2:0] idx,
                                              input logic [13:0] ret, input logic mbe_v,
                                              input logic rbe_v, input logic [1:0] pcw);
        logic hi13;
        logic hi12;
        hi13 = ret[13] & (pcw >= 2'd2);
        hi12 = ret[12] & (pcw >= 2'd1);
        frame_nib = 12'h000;
        if (ext) begin
            case (idx)
                3'd0:    frame_nib = {8'h06, ret[11:8]};
                3'd1:    frame_nib = {8'h03, ret[7:4]};
                3'd2:    frame_nib = {8'h04, ret[3:0]};
                3'd3:    frame_nib = {8'h05, 2'b00, hi13, hi12};
                default: frame_nib = {8'h02, 2'b00, mbe_v, rbe_v};
            endcase
        end else begin
            case (idx)
                3'd0:    frame_nib = {8'h04, ret[11:8]};
                3'd1:    frame_nib = {8'h01, ret[7:4]};
                3'd2:    frame_nib = {8'h02, ret[3:0]};
                default: frame_nib = {8'h03, mbe_v, rbe_v, hi13, hi12};
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t      st_q, st_d;
    logic [1:0]  pcw_q, pcw_d;
    logic        ext_q, ext_d;
    logic [13:0] pc_q, pc_d;
    logic [7:0]  sp_q, sp_d;
    logic [1:0]  rbs_q, rbs_d;
    logic [3:0]  mbs_q, mbs_d;
    logic        mbe_q, mbe_d;
    logic        rbe_q, rbe_d;
    cmd_op_t     op_q, op_d;
    logic [7:0]  arg_q, arg_d;
    logic [7:0]  b1_q, b1_d;
    logic [7:0]  b2_q, b2_d;
    result_t     res_q, res_d;
    logic [2:0]  idx_q, idx_d;
    logic [2:0]  mc_q, mc_d;
    logic [7:0]  div_q, div_d;
    logic        err_q, err_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    mem_t        mem_q, mem_d;
    stk_t        stk_q, stk_d;
    logic        go_q, go_d;
    logic [15:0] ins_q, ins_d;
    logic        busy_q, busy_d;
    logic        iook_q, iook_d;

    logic        acc;
    logic        wr;
    logic        mc_tick;
    logic [2:0]  mc_need;
    logic        work_done;
    logic [11:0] nib;
    logic [13:0] ret_pc;
    logic [13:0] target;

    assign acc     = psel & penable & ~pready_q;
    assign wr      = acc & pwrite;
    assign mc_tick = (div_q == 8'(MC_CLKS - 1));
    assign ret_pc  = pc_q + 14'h0001;
    assign target  = {6'(b1_q[5:0] & hi_mask(pcw_q)), b2_q};
    assign nib     = frame_nib(ext_q, idx_q, ret_pc, mbe_q, rbe_q, pcw_q);

    always_comb begin
        mc_need = 3'(MC_TBL);
        if (op_q == OP_SEL_RB || op_q == OP_SEL_MB)
            mc_need = 3'(MC_SEL);
        else if (res_q == RES_CALL && ext_q)
            mc_need = 3'(MC_CALL_EXT);
    end
    assign work_done = (st_q == ST_WAIT) && (mc_q >= mc_need);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        pcw_d     = pcw_q;
        ext_d     = ext_q;
        pc_d      = pc_q;
        sp_d      = sp_q;
        rbs_d     = rbs_q;
        mbs_d     = mbs_q;
        mbe_d     = mbe_q;
        rbe_d     = rbe_q;
        op_d      = op_q;
        arg_d     = arg_q;
        b1_d      = b1_q;
        b2_d      = b2_q;
        res_d     = res_q;
        idx_d     = idx_q;
        mc_d      = mc_q;
        div_d     = mc_tick ? 8'h00 : div_q + 8'h01;
        err_d     = err_q;
        prdata_d  = prdata_q;
        pready_d  = acc;
        pslverr_d = 1'b0;
        mem_d     = mem_q;
        stk_d     = '0;
        go_d      = 1'b0;
        ins_d     = ins_q;
        busy_d    = (st_q != ST_IDLE);
        iook_d    = ~mbe_q | (mbs_q == MBS_IO);

        if (st_q != ST_IDLE && mc_tick && mc_q != 3'h7)
            mc_d = mc_q + 3'h1;

        case (st_q)
            ST_IDLE: ;
            ST_FETCH_LO: begin
                mem_d.req  = 1'b1;
                mem_d.addr = {6'h00, arg_q};
                if (mem_q.req && mem_ack) begin
                    b1_d       = mem_rdata;
                    mem_d.addr = 14'({6'h00, arg_q} + 14'h0001);
                    st_d       = ST_FETCH_HI;
                end
            end
            ST_FETCH_HI: begin
                if (mem_ack) begin
                    b2_d      = mem_rdata;
                    mem_d.req = 1'b0;
                    // Entry kind decided only once both bytes are in hand
                    case (b1_q[7:6])
                        2'b00:   res_d = RES_BRANCH;
                        2'b01:   res_d = RES_CALL;
                        default: res_d = RES_EXEC;
                    endcase
                    idx_d = 3'h0;
                    st_d  = (b1_q[7:6] == 2'b01) ? ST_PUSH : ST_WAIT;
                end
            end
            ST_PUSH: begin
                stk_d.we    = 1'b1;
                stk_d.addr  = sp_q - nib[11:4];
                stk_d.wdata = nib[3:0];
                idx_d       = idx_q + 3'h1;
                if (idx_q == (ext_q ? 3'd4 : 3'd3))
                    st_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (work_done) begin
                    st_d = ST_IDLE;
                    case (op_q)
                        OP_SEL_RB: begin
                            rbs_d = arg_q[1:0];
                            pc_d  = pc_q + 14'h0002;
                        end
                        OP_SEL_MB: begin
                            mbs_d = arg_q[3:0];
                            pc_d  = pc_q + 14'h0002;
                        end
                        default: begin
                            case (res_q)
                                RES_BRANCH: pc_d = target;
                                RES_CALL: begin
                                    pc_d = target;
                                    sp_d = sp_q - (ext_q ? 8'h06 : 8'h04);
                                end
                                default: begin
                                    // Core runs the stored instruction; its skip is its own
                                    go_d  = 1'b1;
                                    ins_d = {b1_q, b2_q};
                                    pc_d  = ret_pc;
                                end
                            endcase
                        end
                    endcase
                end
            end
            default: st_d = ST_IDLE;
        endcase

        if (acc && !pwrite) begin
            case (paddr)
                OFF_CTRL:   prdata_d = {29'h0, ext_q, pcw_q};
                OFF_CMD:    prdata_d = {22'h0, op_q, arg_q};
                OFF_STATUS: prdata_d = {26'h0, err_q, iook_q, res_q, 1'b0, busy_q};
                OFF_PC:     prdata_d = {18'h0, pc_q};
                OFF_SP:     prdata_d = {24'h0, sp_q};
                OFF_BANK:   prdata_d = {22'h0, rbe_q, mbe_q, mbs_q, 2'b00, rbs_q};
                OFF_EXEC:   prdata_d = {16'h0, ins_q};
                default: begin
                    prdata_d  = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end

        // Engine registers CMD, PC, SP and BANK are frozen against writes while busy; CTRL is written at any time
        if (wr) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                OFF_CTRL: begin
                    pcw_d = pwdata[1:0];
                    ext_d = pwdata[CTRL_EXT_BIT];
                end
                OFF_CMD: begin
                    if (st_q != ST_IDLE) begin
                        pslverr_d = 1'b1;
                    end else begin
                        op_d  = cmd_op_t'(pwdata[CMD_OP_LSB +: 2]);
                        arg_d = pwdata[7:0];
                        res_d = RES_NONE;
                        mc_d  = 3'h0;
                        err_d = 1'b0;
                        case (cmd_op_t'(pwdata[CMD_OP_LSB +: 2]))
                            OP_SEL_RB: st_d = ST_WAIT;
                            OP_SEL_MB: begin
                                // Only banks 0, 1 and 15 are selectable
                                if (pwdata[3:0] == 4'h0 || pwdata[3:0] == 4'h1 || pwdata[3:0] == MBS_IO)
                                    st_d = ST_WAIT;
                                else begin
                                    err_d     = 1'b1;
                                    pslverr_d = 1'b1;
                                end
                            end
                            OP_TBL: st_d = ST_FETCH_LO;
                            default: begin
                                err_d     = 1'b1;
                                pslverr_d = 1'b1;
                            end
                        endcase
                    end
                end
                OFF_PC: if (st_q == ST_IDLE) pc_d = pwdata[13:0];
                OFF_SP: if (st_q == ST_IDLE) sp_d = pwdata[7:0];
                OFF_BANK: if (st_q == ST_IDLE) begin
                    rbs_d = pwdata[1:0];
                    mbs_d = pwdata[BANK_MBS_LSB +: 4];
                    mbe_d = pwdata[BANK_MBE_BIT];
                    rbe_d = pwdata[BANK_RBE_BIT];
                end
                OFF_STATUS, OFF_EXEC: ;
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= ST_IDLE;
            pcw_q     <= RST_PCW;
            ext_q     <= 1'b0;
            pc_q      <= RST_PC;
            sp_q      <= RST_SP;
            rbs_q     <= RST_RBS;
            mbs_q     <= RST_MBS;
            mbe_q     <= 1'b0;
            rbe_q     <= 1'b0;
            op_q      <= OP_NONE;
            arg_q     <= 8'h00;
            b1_q      <= 8'h00;
            b2_q      <= 8'h00;
            res_q     <= RES_NONE;
            idx_q     <= 3'h0;
            mc_q      <= 3'h0;
            div_q     <= 8'h00;
            err_q     <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            mem_q     <= '0;
            stk_q     <= '0;
            go_q      <= 1'b0;
            ins_q     <= 16'h0000;
            busy_q    <= 1'b0;
            iook_q    <= 1'b1;
        end else begin
            st_q      <= st_d;
            pcw_q     <= pcw_d;
            ext_q     <= ext_d;
            pc_q      <= pc_d;
            sp_q      <= sp_d;
            rbs_q     <= rbs_d;
            mbs_q     <= mbs_d;
            mbe_q     <= mbe_d;
            rbe_q     <= rbe_d;
            op_q      <= op_d;
            arg_q     <= arg_d;
            b1_q      <= b1_d;
            b2_q      <= b2_d;
            res_q     <= res_d;
            idx_q     <= idx_d;
            mc_q      <= mc_d;
            div_q     <= div_d;
            err_q     <= err_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            mem_q     <= mem_d;
            stk_q     <= stk_d;
            go_q      <= go_d;
            ins_q     <= ins_d;
            busy_q    <= busy_d;
            iook_q    <= iook_d;
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign mem      = mem_q;
    assign stk      = stk_q;
    assign exec_go  = go_q;
    assign exec_ins = ins_q;
    assign busy     = busy_q;
    assign io_ok    = iook_q;
endmodule

// file: hw/tbl_ind_pkg.sv
// Constants and types shared by the table-indirect and bank-select block
package tbl_ind_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CMD    = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PC     = 8'h0C;
    localparam logic [7:0] OFF_SP     = 8'h10;
    localparam logic [7:0] OFF_BANK   = 8'h14;
    localparam logic [7:0] OFF_EXEC   = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_EXT_BIT  = 2;
    localparam int CMD_OP_LSB    = 8;
    localparam int BANK_MBS_LSB  = 4;
    localparam int BANK_MBE_BIT  = 8;
    localparam int BANK_RBE_BIT  = 9;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  RST_PCW  = 2'h0;
    localparam logic [13:0] RST_PC   = 14'h0000;
    localparam logic [7:0]  RST_SP   = 8'h00;
    localparam logic [3:0]  RST_MBS  = 4'h0;
    localparam logic [1:0]  RST_RBS  = 2'h0;
    // ------------------------------------------------------------
    // Timing counts in machine cycles, clocks per machine cycle
    // ------------------------------------------------------------
    localparam int MC_DIV       = 4;
    localparam int MC_SEL       = 2;
    localparam int MC_TBL       = 3;
    localparam int MC_CALL_EXT  = 4;
    localparam logic [3:0] MBS_IO = 4'hF;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {OP_SEL_RB, OP_SEL_MB, OP_TBL, OP_NONE} cmd_op_t;
    typedef enum logic [1:0] {RES_NONE, RES_BRANCH, RES_CALL, RES_EXEC} result_t;
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [3:0] wdata;
    } stk_t;
    typedef struct packed {
        logic        req;
        logic [13:0] addr;
    } mem_t;
endpackage

// file: tb/tbl_mem_model.sv
// Program memory model that answers table fetches
`timescale 1ns/10ps
module tbl_mem_model
    import tbl_ind_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Fetch port
    input  wire mem_t       mem,
    input  wire logic       slow,
    output logic [7:0]      mem_rdata,
    output logic            mem_ack
);
    logic [7:0] rom [256];
    int         wait_n;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'h0;
            mem_rdata <= 8'h00;
            wait_n    <= 0;
        end else if (mem.req && !mem_ack && wait_n >= (slow ? 3 : 0)) begin
            mem_ack   <= 1'h1;
            mem_rdata <= rom[mem.addr[7:0]];
            wait_n    <= 0;
        end else begin
            mem_ack   <= 1'h0;
            // Toggle so stale data never looks valid
            mem_rdata <= ~mem_rdata;
            wait_n    <= mem.req ? wait_n + 1 : 0;
        end
    end
endmodule

// file: tb/tbl_ind_checker.sv
// Port assertions for the table-indirect block
`timescale 1ns/10ps
module tbl_ind_checker
    import tbl_ind_pkg::*;
#(
    parameter int MC_CLKS = MC_DIV
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire mem_t        mem,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_ack,
    input wire stk_t        stk,
    input wire logic        exec_go,
    input wire logic [15:0] exec_ins,
    input wire logic        busy,
    input wire logic        io_ok
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc1;
    logic [1:0] acks_q;
    logic [1:0] acks_d;
    assign acc1 = psel && penable && !pready;
    always_comb begin
        acks_d = acks_q;
        if (!mem.req) acks_d = 2'h0;
        else if (mem_ack) acks_d = acks_q + 2'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) acks_q <= 2'h0;
        else acks_q <= acks_d;
    end
    sequence first_ack;
        mem.req && mem_ack && acks_q == 2'h0;
    endsequence
    sequence second_ack;
        mem.req && mem_ack && acks_q == 2'h1;
    endsequence
    chk_pready_wait: assert property (acc1 |=> pready)
        else $error("pready late");
    chk_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    chk_unmapped_err: assert property (acc1 && paddr > OFF_EXEC |=> pslverr && prdata == 32'h0)
        else $error("unmapped access accepted");
    chk_fetch_hold: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
        else $error("fetch moved before ack");
    chk_first_byte: assert property (first_ack |=> mem.req && mem.addr == $past(mem.addr) + 14'h1)
        else $error("second byte address wrong");
    chk_second_byte: assert property (second_ack |=> !mem.req)
        else $error("fetch not ended");
    chk_exec_pulse: assert property (exec_go |=> !exec_go)
        else $error("exec_go too long");
    chk_exec_hold: assert property (!exec_go |-> $stable(exec_ins))
        else $error("exec_ins changed alone");
    chk_stk_busy: assert property (stk.we |-> busy)
        else $error("stack write while idle");
    chk_cmd_refused: assert property ((acc1 && pwrite && paddr == OFF_CMD && busy) ##1 busy |-> pslverr)
        else $error("command accepted while busy");
endmodule
bind tbl_ind_core tbl_ind_checker #(.MC_CLKS(MC_CLKS)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .stk(stk),
    .exec_go(exec_go), .exec_ins(exec_ins), .busy(busy), .io_ok(io_ok));

// file: tb/tb_top.sv
// Self-checking testbench for the table-indirect block
`timescale 1ns/10ps
module tb_top
    import tbl_ind_pkg::*;
;
    logic        pclk = 1'h0, presetn = 1'h0, slow = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00, mem_rdata;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, mem_ack, exec_go, busy, io_ok;
    logic [15:0] exec_ins, last_ins;
    mem_t        mem;
    stk_t        stk;
    logic [11:0] sq[$];
    int          fail_count = 0, comparisons = 0, n_exec = 0;
    always #20 pclk = ~pclk;
    tbl_ind_core #(.MC_CLKS(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .stk(stk), .exec_go(exec_go),
        .exec_ins(exec_ins), .busy(busy), .io_ok(io_ok));
    tbl_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem(mem), .slow(slow),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    always @(posedge pclk) begin
        if (stk.we === 1'h1) sq.push_back({stk.addr, stk.wdata});
        if (exec_go === 1'h1) begin
            n_exec++;
            last_ins = exec_ins;
        end
    end
    // ----------
    // Helpers
    // ----------
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // No cycle count assumed; only the watchdog ends a hung wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    // Second write while busy must be refused
    task automatic run(input logic [1:0] op, input logic [7:0] v, input logic dup);
        apb(1'h1, OFF_CMD, {22'h0, op, v});
        if (dup) begin
            apb(1'h1, OFF_CMD, {22'h0, op, v});
            chk("cmd busy", er, 32'h1);
        end
        repeat (2) @(posedge pclk);
        while (busy !== 1'h0) begin
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_reset;
        rchk("pc", OFF_PC, 32'h0);
        rchk("sp", OFF_SP, 32'h0);
        rchk("bank", OFF_BANK, 32'h0);
        rchk("ctrl", OFF_CTRL, 32'h0);
        chk("io_ok", io_ok, 32'h1);
        rchk("unmapped", 8'h1C, 32'h0);
        chk("unmapped err", er, 32'h1);
    endtask
    task automatic t_sel;
        run(2'h0, 8'h03, 1'h0);
        rchk("rbs", OFF_BANK, 32'h3);
        rchk("pc sel", OFF_PC, 32'h2);
        run(2'h1, 8'h0F, 1'h0);
        rchk("mbs", OFF_BANK, 32'hF3);
        run(2'h1, 8'h02, 1'h0);
        chk("mbs bad", er, 32'h1);
        rchk("mbs kept", OFF_BANK, 32'hF3);
        rchk("status err", OFF_STATUS, 32'h30);
        run(2'h3, 8'h00, 1'h0);
        chk("op refused", er, 32'h1);
        rchk("status op", OFF_STATUS, 32'h30);
    endtask
    task automatic t_io;
        apb(1'h1, OFF_BANK, 32'h110);
        repeat (3) @(posedge pclk);
        chk("io_ok off", io_ok, 32'h0);
        apb(1'h1, OFF_BANK, 32'h1F0);
        repeat (3) @(posedge pclk);
        chk("io_ok on", io_ok, 32'h1);
    endtask
    task automatic t_branch;
        logic [5:0] msk;
        u_mem.rom[8'h20] = 8'h3F;
        u_mem.rom[8'h21] = 8'h5A;
        for (int w = 0; w < 3; w++) begin
            msk = (w == 0) ? 6'h0F : (w == 1) ? 6'h1F : 6'h3F;
            apb(1'h1, OFF_CTRL, 32'(w));
            apb(1'h1, OFF_PC, 32'h100);
            run(2'h2, 8'h20, 1'h0);
            rchk("branch pc", OFF_PC, {18'h0, msk, 8'h5A});
        end
    endtask
    task automatic t_call(input logic ext);
        logic [11:0] e[$];
        if (ext) e = '{12'h7A1, 12'h7D2, 12'h7C4, 12'h7B3, 12'h7E3};
        else e = '{12'h7C1, 12'h7F2, 12'h7E4, 12'h7DF};
        u_mem.rom[8'h22] = 8'h45;
        u_mem.rom[8'h23] = 8'h66;
        slow <= ext;
        apb(1'h1, OFF_CTRL, {29'h0, ext, 2'h2});
        apb(1'h1, OFF_PC, 32'h3123);
        apb(1'h1, OFF_SP, 32'h80);
        apb(1'h1, OFF_BANK, 32'h3F0);
        sq.delete();
        run(2'h2, 8'h22, ext);
        chk("frame len", 32'(sq.size()), 32'(e.size()));
        foreach (e[i]) chk("frame", sq[i], e[i]);
        rchk("call sp", OFF_SP, ext ? 32'h7A : 32'h7C);
        rchk("call pc", OFF_PC, 32'h0566);
        rchk("call status", OFF_STATUS, 32'h18);
    endtask
    task automatic t_exec;
        u_mem.rom[8'h24] = 8'hA7;
        u_mem.rom[8'h25] = 8'h3C;
        apb(1'h1, OFF_PC, 32'h200);
        n_exec = 0;
        run(2'h2, 8'h24, 1'h0);
        chk("exec count", 32'(n_exec), 32'h1);
        chk("exec ins", last_ins, 32'hA73C);
        rchk("exec reg", OFF_EXEC, 32'hA73C);
        rchk("exec pc", OFF_PC, 32'h201);
        rchk("exec status", OFF_STATUS, 32'h1C);
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_reset;
        t_sel;
        t_io;
        t_branch;
        t_call(1'h0);
        t_call(1'h1);
        t_exec;
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_of_test;
    end
endmodule
